// ### rtl/hpe_pkg.sv
// Package of register map, field layout and state types for the port error and byte count logic.
package hpe_pkg;
    // Register byte offsets.
    localparam logic [7:0] HPE_CTRL_OFS     = 8'h00;
    localparam logic [7:0] HPE_STATUS_OFS   = 8'h04;
    localparam logic [7:0] HPE_ISSUE_OFS    = 8'h08;
    localparam logic [7:0] HPE_ACTIVE_OFS   = 8'h0c;
    localparam logic [7:0] HPE_SEL_OFS      = 8'h10;
    localparam logic [7:0] HPE_COUNT_OFS    = 8'h14;
    localparam logic [7:0] HPE_STATE_OFS    = 8'h18;
    // Control register fields.
    localparam int HPE_CTRL_RUN_BIT   = 0;
    localparam int HPE_CTRL_SWEN_BIT  = 1;
    localparam int HPE_CTRL_DDIE_BIT  = 2;
    localparam int HPE_CTRL_GIE_BIT   = 3;
    localparam int HPE_CTRL_CLRC_BIT  = 4;
    // Status register fields, write one to clear except CR (bit 5), which a write does not change.
    localparam int HPE_ST_IFS_BIT  = 0;
    localparam int HPE_ST_PSS_BIT  = 1;
    localparam int HPE_ST_TFES_BIT = 2;
    localparam int HPE_ST_OFS_BIT  = 3;
    localparam int HPE_ST_DPS_BIT  = 4;
    localparam int HPE_ST_CR_BIT   = 5;
    localparam logic [31:0] HPE_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] HPE_UNMAPPED  = 32'h0000_0000;
    localparam int HPE_SLOTS = 32;

    typedef enum logic [2:0] {
        HPE_IDLE,
        HPE_FATAL,
        HPE_FATAL_TF,
        HPE_WAIT_CLEAR,
        HPE_NON_FATAL,
        HPE_SW_IDLE,
        HPE_SW_ONE_DEV_ERR
    } hpe_state_e;

    // Error events from the link and transport side.
    typedef struct packed {
        logic fatal;
        logic single_dev;
        logic pio_i_fail;
        logic taskfile_err;
        logic non_fatal;
        logic sw_recovered;
    } hpe_err_s;

    // One completed data frame.
    typedef struct packed {
        logic        valid;
        logic        good;
        logic [4:0]  slot;
        logic [15:0] words;
        logic [15:0] desc_words;
        logic        queued;
        logic        last_of_desc;
        logic        desc_irq;
    } hpe_frame_s;
endpackage

// ### rtl/hpe_count.sv
// Per-slot transferred byte count store with padding-aware increment.
`timescale 1ns/1ps
module hpe_count
    import hpe_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // Update port
    input  wire logic        upd_in,
    input  wire logic [4:0]  upd_slot_in,
    input  wire logic [15:0] upd_words_in,
    input  wire logic [15:0] upd_limit_in,
    input  wire logic        clr_in,
    input  wire logic [4:0]  clr_slot_in,
    // Read port
    input  wire logic [4:0]  rd_slot_in,
    output logic      [31:0] rd_count_out,
    output logic             ovf_out
);
    logic [31:0] cnt_q [HPE_SLOTS];
    logic [15:0] eff;
    logic        ovf;

    // One padding word above the descriptor word count is the zero fill, not overflow.
    always_comb begin
        eff = upd_words_in;
        ovf = 1'b0;
        if (upd_words_in > upd_limit_in) begin
            eff = upd_limit_in;
            ovf = (upd_words_in != 16'(upd_limit_in + 16'h0001));
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < HPE_SLOTS; i++) begin
                cnt_q[i] <= 32'h0000_0000;
            end
            rd_count_out <= 32'h0000_0000;
            ovf_out      <= 1'b0;
        end else if (ce_in) begin
            ovf_out <= upd_in & ovf;
            if (clr_in) begin
                cnt_q[clr_slot_in] <= 32'h0000_0000;
            end
            if (upd_in) begin
                cnt_q[upd_slot_in] <= cnt_q[upd_slot_in] + {15'h0000, eff, 1'b0};
            end
            rd_count_out <= cnt_q[rd_slot_in];
        end
    end
endmodule

// ### rtl/hpe_port.sv
// Port error state machine, slot vectors, byte counts and descriptor-done interrupt over Wishbone.
`timescale 1ns/1ps
module hpe_port
    import hpe_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Transport events
    input  wire hpe_err_s    err_in,
    input  wire hpe_frame_s  frame_in,
    input  wire logic        cmd_done_in,
    input  wire logic [4:0]  cmd_slot_in,
    input  wire logic        tag_done_in,
    input  wire logic [4:0]  tag_slot_in,
    // Outputs
    output logic             irq_out,
    output logic             halted_out,
    output logic             count_ovf_out
);
    typedef struct packed {
        hpe_state_e  st;
        logic [31:0] ctrl;
        logic [5:0]  stat;
        logic [31:0] issue;
        logic [31:0] active;
        logic [4:0]  sel;
        logic        desc_pend;
        logic        done_pend;
        logic [4:0]  done_slot;
        logic        ack;
        logic [31:0] rdat;
    } hpe_regs_s;

    hpe_regs_s r_q;
    hpe_regs_s r_d;
    logic [31:0] count_rd;
    logic        ovf_pulse;
    logic        wr;
    logic        rd_cycle;
    logic        clr_cnt;
    logic        upd;

    function automatic logic [31:0] hpe_mask(input logic [31:0] d, input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & d;
    endfunction

    assign rd_cycle = wb_cyc_in & wb_stb_in & ~r_q.ack;
    assign wr       = rd_cycle & wb_we_in;
    assign upd      = frame_in.valid & frame_in.good & ~frame_in.queued;
    assign clr_cnt  = wr & (wb_adr_in == HPE_COUNT_OFS);

    hpe_count u_count (
        .mclk_in      (mclk_in),
        .rst_in       (rst_in),
        .ce_in        (ce_in),
        .upd_in       (upd),
        .upd_slot_in  (frame_in.slot),
        .upd_words_in (frame_in.words),
        .upd_limit_in (frame_in.desc_words),
        .clr_in       (clr_cnt),
        .clr_slot_in  (r_q.sel),
        .rd_slot_in   (r_q.sel),
        .rd_count_out (count_rd),
        .ovf_out      (ovf_pulse)
    );

    always_comb begin
        logic [31:0] m;
        logic [5:0]  set;
        logic        run;
        logic        sw;
        m   = hpe_mask(wb_dat_in, wb_sel_in);
        set = 6'h00;
        r_d = r_q;
        run = r_q.ctrl[HPE_CTRL_RUN_BIT];
        sw  = r_q.ctrl[HPE_CTRL_SWEN_BIT];
        r_d.ack = rd_cycle;
        case (r_q.st)
            HPE_IDLE, HPE_SW_IDLE: begin
                if (err_in.taskfile_err) begin
                    r_d.st = HPE_FATAL_TF;
                end else if (err_in.fatal) begin
                    r_d.st = HPE_FATAL;
                end else if (err_in.non_fatal) begin
                    r_d.st = HPE_NON_FATAL;
                end
            end
            HPE_FATAL: begin
                set[HPE_ST_IFS_BIT] = 1'b1;
                set[HPE_ST_PSS_BIT] = err_in.pio_i_fail;
                r_d.st = (sw && err_in.single_dev) ? HPE_SW_ONE_DEV_ERR : HPE_WAIT_CLEAR;
            end
            HPE_FATAL_TF: begin
                set[HPE_ST_TFES_BIT] = 1'b1;
                r_d.st = sw ? HPE_SW_ONE_DEV_ERR : HPE_WAIT_CLEAR;
            end
            HPE_WAIT_CLEAR: begin
                if (!run) begin
                    r_d.st = HPE_IDLE;
                end
            end
            HPE_NON_FATAL: begin
                r_d.st = sw ? HPE_SW_IDLE : HPE_IDLE;
            end
            HPE_SW_ONE_DEV_ERR: begin
                if (err_in.sw_recovered) begin
                    r_d.st = HPE_SW_IDLE;
                end
            end
            default: begin
                r_d.st = HPE_IDLE;
            end
        endcase
        set[HPE_ST_OFS_BIT] = ovf_pulse;
        // Descriptor interrupt is latched per frame and released only on a good frame end.
        if (frame_in.valid && frame_in.desc_irq) begin
            r_d.desc_pend = 1'b1;
        end
        if (r_q.desc_pend && frame_in.valid && frame_in.good && frame_in.last_of_desc) begin
            set[HPE_ST_DPS_BIT] = 1'b1;
            r_d.desc_pend = 1'b0;
        end else if (frame_in.valid && !frame_in.good) begin
            r_d.desc_pend = 1'b0;
        end
        // Completion waits one cycle so the count store has absorbed the last frame.
        r_d.done_pend = cmd_done_in;
        r_d.done_slot = cmd_slot_in;
        if (r_q.done_pend) begin
            r_d.issue[r_q.done_slot] = 1'b0;
        end
        if (tag_done_in) begin
            r_d.active[tag_slot_in] = 1'b0;
        end
        if (wr) begin
            case (wb_adr_in)
                HPE_CTRL_OFS:   r_d.ctrl = (r_q.ctrl & ~hpe_mask(32'hffff_ffff, wb_sel_in)) | m;
                HPE_STATUS_OFS: r_d.stat = r_q.stat & ~{1'b0, m[4:0]};
                HPE_ISSUE_OFS:  r_d.issue = r_d.issue | m;
                HPE_ACTIVE_OFS: r_d.active = r_d.active | m;
                HPE_SEL_OFS:    r_d.sel = m[4:0];
                default: begin
                end
            endcase
        end
        // Hardware sets win over a same-cycle software clear.
        r_d.stat = r_d.stat | set;
        // Dropping run clears running flag and the outstanding vectors.
        if (!r_d.ctrl[HPE_CTRL_RUN_BIT]) begin
            r_d.stat[HPE_ST_CR_BIT] = 1'b0;
            r_d.issue = 32'h0000_0000;
            r_d.active = 32'h0000_0000;
        end else if (r_q.st == HPE_FATAL || r_q.st == HPE_FATAL_TF) begin
            r_d.stat[HPE_ST_CR_BIT] = 1'b0;
        end else if (!run && r_q.st != HPE_WAIT_CLEAR) begin
            r_d.stat[HPE_ST_CR_BIT] = 1'b1;
        end
        case (wb_adr_in)
            HPE_CTRL_OFS:   r_d.rdat = r_q.ctrl;
            HPE_STATUS_OFS: r_d.rdat = {26'h000_0000, r_q.stat};
            HPE_ISSUE_OFS:  r_d.rdat = r_q.issue;
            HPE_ACTIVE_OFS: r_d.rdat = r_q.active;
            HPE_SEL_OFS:    r_d.rdat = {27'h000_0000, r_q.sel};
            HPE_COUNT_OFS:  r_d.rdat = count_rd;
            HPE_STATE_OFS:  r_d.rdat = {29'h0000_0000, r_q.st};
            default:        r_d.rdat = HPE_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            r_q <= '{st: HPE_IDLE, ctrl: HPE_CTRL_RST, default: '0};
        end else if (ce_in) begin
            r_q <= r_d;
        end
    end

    assign wb_ack_out    = r_q.ack;
    assign wb_dat_out    = r_q.rdat;
    assign irq_out       = r_q.stat[HPE_ST_DPS_BIT] & r_q.ctrl[HPE_CTRL_DDIE_BIT] & r_q.ctrl[HPE_CTRL_GIE_BIT];
    assign halted_out    = (r_q.st == HPE_WAIT_CLEAR);
    assign count_ovf_out = r_q.stat[HPE_ST_OFS_BIT];

    fatal_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && r_q.st == HPE_FATAL |=> r_q.stat[HPE_ST_IFS_BIT]) else $error("fatal flag not set");
    fatal_next_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && r_q.st == HPE_FATAL && !(r_q.ctrl[HPE_CTRL_SWEN_BIT] && err_in.single_dev)
        |=> r_q.st == HPE_WAIT_CLEAR) else $error("fatal wrong next");
    pio_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && r_q.st == HPE_FATAL && err_in.pio_i_fail |=> r_q.stat[HPE_ST_PSS_BIT]) else $error("pio flag");
    tf_path_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && r_q.st == HPE_FATAL_TF && r_q.ctrl[HPE_CTRL_SWEN_BIT]
        |=> r_q.st == HPE_SW_ONE_DEV_ERR && r_q.stat[HPE_ST_TFES_BIT]) else $error("taskfile path");
    halt_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && r_q.st == HPE_WAIT_CLEAR && r_q.ctrl[HPE_CTRL_RUN_BIT] |=> r_q.st == HPE_WAIT_CLEAR)
        else $error("halt left early");
    cr_drop_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !r_q.ctrl[HPE_CTRL_RUN_BIT] |-> !r_q.stat[HPE_ST_CR_BIT]) else $error("running flag stuck");
    nonfatal_ret_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && r_q.st == HPE_NON_FATAL && !r_q.ctrl[HPE_CTRL_SWEN_BIT] |=> r_q.st == HPE_IDLE)
        else $error("non fatal return");
    irq_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        irq_out |-> r_q.ctrl[HPE_CTRL_GIE_BIT] && $past(r_q.stat[HPE_ST_DPS_BIT]) || r_q.stat[HPE_ST_DPS_BIT])
        else $error("irq without cause");
    bad_crc_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ce_in && frame_in.valid && !frame_in.good && !r_q.stat[HPE_ST_DPS_BIT] |=> !r_q.stat[HPE_ST_DPS_BIT])
        else $error("done on bad crc");
    wb_ack_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        wb_ack_out |=> !wb_ack_out) else $error("ack held"); 

    fatal_c: cover property (@(posedge mclk_in) disable iff (rst_in) r_q.st == HPE_WAIT_CLEAR ##[1:50] r_q.st == HPE_IDLE);
    swerr_c: cover property (@(posedge mclk_in) disable iff (rst_in) r_q.st == HPE_SW_ONE_DEV_ERR);
    dps_c:   cover property (@(posedge mclk_in) disable iff (rst_in) irq_out);
    ovf_c:   cover property (@(posedge mclk_in) disable iff (rst_in) ovf_pulse);
endmodule

// ### testbench/hpe_dev_model.sv
// Behavioural model of the storage device that raises error events and completes data frames.
`timescale 1ns/1ps
module hpe_dev_model
    import hpe_pkg::*;
(
    // Clock
    input  wire logic mclk_in,
    // Transport events toward the port
    output hpe_err_s   err_out,
    output hpe_frame_s frame_out
);
    initial begin
        err_out   = '0;
        frame_out = '0;
    end
    // The word count includes the zero-filled padding word of an odd final frame.
    task automatic send_frame(input logic [4:0] s, input logic [15:0] w, input logic [15:0] lim,
                              input logic good, input logic q, input logic last, input logic irq);
        hpe_frame_s f;
        f = '{valid: 1'b1, good: good, slot: s, words: w, desc_words: lim, queued: q,
              last_of_desc: last, desc_irq: irq};
        @(posedge mclk_in);
        frame_out <= f;
        @(posedge mclk_in);
        // Released fields show the inverse so a stale value is never mistaken for fresh data.
        frame_out       <= ~f;
        frame_out.valid <= 1'b0;
    endtask
    task automatic raise_err(input hpe_err_s e);
        @(posedge mclk_in);
        err_out <= e;
        repeat (2) @(posedge mclk_in);
        err_out <= '0;
    endtask
endmodule

// ### testbench/host_port_error_prd_logic_test.sv
// Self-checking bench for the port error states, slot vectors, byte counts and descriptor interrupt.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module host_port_error_prd_logic_test;
    import hpe_pkg::*;
    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b1;
    logic        cyc     = 1'b0;
    logic        we      = 1'b0;
    logic        cmd_done = 1'b0;
    logic        tag_done = 1'b0;
    logic [4:0]  cmd_slot = '0;
    logic [4:0]  tag_slot = '0;
    logic [7:0]  adr     = '0;
    logic [31:0] wdat    = '0;
    logic [31:0] rdat, rd, exp_c;
    logic        ack, irq, halted, ovf;
    hpe_err_s    err;
    hpe_frame_s  frame;
    int          err_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          s, s2, lim, w;
    logic        good;

    always #2.5 mclk_in = ~mclk_in;

    hpe_dev_model dev (.mclk_in(mclk_in), .err_out(err), .frame_out(frame));
    hpe_port DUT (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .err_in(err), .frame_in(frame), .cmd_done_in(cmd_done), .cmd_slot_in(cmd_slot),
        .tag_done_in(tag_done), .tag_slot_in(tag_slot), .irq_out(irq), .halted_out(halted),
        .count_ovf_out(ovf));

    function automatic logic [5:0] st(input int i);
        return 6'h01 << i;
    endfunction
    function automatic logic [31:0] bytes(input logic [15:0] wd, input logic [15:0] l, input logic ok);
        return ok ? 32'((wd < l ? wd : l) * 2) : 32'h0000_0000;
    endfunction
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // The request stands until ack is sampled high; read data is taken at that same edge.
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        cyc <= 1'b1; we <= wr; adr <= a; wdat <= d;
        @(posedge mclk_in);
        while (ack !== 1'b1) @(posedge mclk_in);
        rd = rdat;
        cyc <= 1'b0;
    endtask
    task automatic reboot(input logic [31:0] ctl);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        wb(1, HPE_CTRL_OFS, ctl);
    endtask
    task automatic err_case(input logic [31:0] ctl, input logic [5:0] e, input hpe_state_e x,
                            input logic [5:0] m, input logic [5:0] v);
        reboot(ctl);
        dev.raise_err(hpe_err_s'(e));
        repeat (4) @(posedge mclk_in);
        wb(0, HPE_STATE_OFS, 0);
        `CHK(rd[2:0], x)
        wb(0, HPE_STATUS_OFS, 0);
        `CHK(rd[5:0] & m, v)
    endtask
    task automatic frame_chk(input logic [15:0] wd, input logic q);
        dev.send_frame(5'(s), wd, 16'(lim), good, q, 1'b0, 1'b0);
        exp_c = exp_c + bytes(wd, 16'(lim), good && !q);
        repeat (3) @(posedge mclk_in);
        wb(0, HPE_COUNT_OFS, 0);
        `CHK(rd, exp_c)
    endtask

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        void'($urandom(50));
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        wb(0, HPE_CTRL_OFS, 0);
        `CHK(rd, HPE_CTRL_RST)
        wb(0, 8'h1c, 0);
        `CHK(rd, HPE_UNMAPPED)
        $display("test reset done");
        err_case(1, 6'h28, HPE_WAIT_CLEAR, st(0) | st(1) | st(5), st(0) | st(1));
        `CHK(halted, 1'b1)
        wb(1, HPE_CTRL_OFS, 0);
        repeat (3) @(posedge mclk_in);
        wb(0, HPE_STATE_OFS, 0);
        `CHK(rd[2:0], HPE_IDLE)
        `CHK(halted, 1'b0)
        err_case(1, 6'h24, HPE_WAIT_CLEAR, st(2), st(2));
        err_case(3, 6'h24, HPE_SW_ONE_DEV_ERR, st(2), st(2));
        err_case(3, 6'h20, HPE_WAIT_CLEAR, st(0), st(0));
        err_case(3, 6'h30, HPE_SW_ONE_DEV_ERR, st(0), st(0));
        err_case(1, 6'h02, HPE_IDLE, st(0) | st(5), st(5));
        err_case(3, 6'h02, HPE_SW_IDLE, st(0), 6'h00);
        $display("test error states done");
        reboot(1);
        s = $urandom % 32;
        s2 = (s + 1 + $urandom % 31) % 32;
        wb(1, HPE_ACTIVE_OFS, 32'h1 << s);
        wb(1, HPE_ISSUE_OFS, 32'h1 << s);
        wb(1, HPE_ISSUE_OFS, 32'h1 << s2);
        wb(0, HPE_ISSUE_OFS, 0);
        `CHK(rd, (32'h1 << s) | (32'h1 << s2))
        @(posedge mclk_in);
        cmd_done <= 1'b1; cmd_slot <= 5'(s); tag_done <= 1'b1; tag_slot <= 5'(s);
        @(posedge mclk_in);
        cmd_done <= 1'b0; tag_done <= 1'b0;
        repeat (3) @(posedge mclk_in);
        wb(0, HPE_ISSUE_OFS, 0);
        `CHK(rd, 32'h1 << s2)
        wb(0, HPE_ACTIVE_OFS, 0);
        `CHK(rd, 32'h0000_0000)
        $display("test slot vectors done");
        for (int i = 0; i < 12; i++) begin
            s = $urandom % 32;
            lim = 1 + $urandom % 64;
            good = ($urandom % 4) != 0;
            wb(1, HPE_SEL_OFS, 32'(s));
            wb(1, HPE_COUNT_OFS, 0);
            exp_c = 32'h0000_0000;
            frame_chk(16'(lim - 1 + $urandom % 3), i == 5);
            good = 1'b1;
            frame_chk(16'(lim + 1), 1'b0);
        end
        wb(0, HPE_STATUS_OFS, 0);
        `CHK(rd[HPE_ST_OFS_BIT], 1'b0)
        dev.send_frame(5'(s), 16'(lim + 2), 16'(lim), 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge mclk_in);
        `CHK(ovf, 1'b1)
        wb(1, HPE_STATUS_OFS, st(HPE_ST_OFS_BIT));
        `CHK(ovf, 1'b0)
        $display("test byte counts done");
        wb(1, HPE_CTRL_OFS, 32'h0000_000d);
        dev.send_frame(5'h00, 16'h0004, 16'h0004, 1'b1, 1'b0, 1'b0, 1'b1);
        dev.send_frame(5'h00, 16'h0004, 16'h0004, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge mclk_in);
        `CHK(irq, 1'b0)
        dev.send_frame(5'h00, 16'h0004, 16'h0004, 1'b1, 1'b0, 1'b0, 1'b1);
        repeat (3) @(posedge mclk_in);
        `CHK(irq, 1'b0)
        dev.send_frame(5'h00, 16'h0004, 16'h0004, 1'b1, 1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge mclk_in);
        for (int i = 0; i < 4; i++) begin
            wb(1, HPE_CTRL_OFS, 32'(1 | (i << 2)));
            @(posedge mclk_in);
            `CHK(irq, i == 3)
        end
        wb(1, HPE_STATUS_OFS, st(HPE_ST_DPS_BIT));
        @(posedge mclk_in);
        `CHK(irq, 1'b0)
        $display("test descriptor interrupt done");
        close_out();
    end
endmodule
